// *** hdl/phy_mgmt_control_status_regs.sv ***
// management register slice: straps, cable test, soft resets, link and power state
`timescale 1ns/1ps
module phy_mgmt_control_status_regs
	import phy_mgmt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_writedata_i,
	input wire logic [DATA_W/8-1:0] avs_byteenable_i,
	output logic [DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [PHY_ADDR_W-1:0] strap_phy_address_i,
	input wire logic strap_auto_mode_i,
	input wire logic link_up_i,
	input wire logic link_down_i,
	input wire logic send_data_i,
	input wire logic link_status_i,
	input wire logic descr_lock_i,
	input wire logic loc_rcvr_i,
	input wire logic rem_rcvr_i,
	input wire logic tdr_done_i,
	input wire logic tdr_fail_i,
	input wire logic sleep_request_i,
	output logic tdr_start_o,
	output logic core_reset_o,
	output logic line_energy_detect_enable_o,
	output logic sleep_allow_o,
	output logic sleep_enter_o,
	output logic power_normal_o,
	output logic irq_o
);
	typedef struct packed {
		logic waitreq;
		logic [DATA_W-1:0] rdata;
		logic [PHY_ADDR_W-1:0] phy_addr;
		logic ct_start;
		logic ct_auto;
		logic ct_done;
		logic ct_fail;
		tdr_state_t tdr;
		logic tdr_pulse;
		logic [REG_W-1:0] sr_spare;
		logic full_req;
		logic core_req;
		logic [CNT_W-1:0] core_cnt;
		logic core_rst;
		logic link_prev;
		logic [REG_W-1:0] link_flags;
		logic line_energy_detect_enable;
		logic sleep_en;
		logic auto_mode;
		logic [LP_SPARE_W-1:0] lp_spare;
		logic stby_req;
		logic norm_req;
		logic pwr_normal;
		logic sleep_enter;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic [IDX_W-1:0] idx;
	logic wr_lo;
	logic wr_hi;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rd_word;
	logic link_fell;
	logic launch;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_clear;

	assign idx = avs_address_i[ADDR_W-1:ADDR_LSB];
	assign wdata = avs_writedata_i[REG_W-1:0];
	// a write takes effect only at the edge where waitrequest is seen low
	assign wr_lo = avs_write_i & ~state_reg.waitreq & avs_byteenable_i[0];
	assign wr_hi = avs_write_i & ~state_reg.waitreq & avs_byteenable_i[1];
	assign link_fell = state_reg.link_prev & ~link_status_i;
	assign launch = state_reg.ct_start | (state_reg.ct_auto & link_fell);

	// read mux; unmapped indices read as zero
	always_comb begin
		rd_word = REG_RESET;
		unique case (idx)
			IDX_STRAP_ADDR: begin
				rd_word[PHY_ADDR_W-1:0] = state_reg.phy_addr;
			end
			IDX_CABLE_TEST: begin
				rd_word[CT_START_BIT] = state_reg.ct_start;
				rd_word[CT_AUTO_BIT] = state_reg.ct_auto;
				rd_word[CT_DONE_BIT] = state_reg.ct_done;
				rd_word[CT_FAIL_BIT] = state_reg.ct_fail;
			end
			IDX_SOFT_RESET: begin
				rd_word = state_reg.sr_spare & SR_SPARE_MASK;
				rd_word[SR_FULL_BIT] = state_reg.full_req;
				rd_word[SR_CORE_BIT] = state_reg.core_req;
			end
			IDX_LINK_FLAGS: begin
				rd_word = state_reg.link_flags;
			end
			IDX_LOW_POWER: begin
				rd_word[LP_SPARE_W-1:0] = state_reg.lp_spare;
				rd_word[LP_ED_BIT] = state_reg.line_energy_detect_enable;
				rd_word[LP_SLEEP_BIT] = state_reg.sleep_en;
				rd_word[LP_AUTO_BIT] = state_reg.auto_mode;
			end
			IDX_PWR_REQUEST: begin
				rd_word[PM_STANDBY_BIT] = state_reg.stby_req;
				rd_word[PM_NORMAL_BIT] = state_reg.norm_req;
			end
			IDX_IRQ_STATUS: begin
				rd_word[IRQ_W-1:0] = state_reg.irq_stat;
			end
			IDX_IRQ_MASK: begin
				rd_word[IRQ_W-1:0] = state_reg.irq_mask;
			end
			default: begin
				rd_word = REG_RESET;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		irq_event = IRQ_RESET;
		irq_clear = IRQ_RESET;

		// bus handshake: one wait cycle, then waitrequest low for one cycle
		state_next.waitreq = ~((avs_read_i | avs_write_i) & state_reg.waitreq);
		if (avs_read_i & state_reg.waitreq) begin
			state_next.rdata = {{(DATA_W-REG_W){1'b0}}, rd_word};
		end

		// live status copies
		state_next.link_prev = link_status_i;
		state_next.link_flags = REG_RESET;
		state_next.link_flags[LS_UP_BIT] = link_up_i;
		state_next.link_flags[LS_DOWN_BIT] = link_down_i;
		state_next.link_flags[LS_SEND_BIT] = send_data_i;
		state_next.link_flags[LS_STATUS_BIT] = link_status_i;
		state_next.link_flags[LS_DESCR_BIT] = descr_lock_i;
		state_next.link_flags[LS_LOC_BIT] = loc_rcvr_i;
		state_next.link_flags[LS_REM_BIT] = rem_rcvr_i;
		if (state_reg.link_prev != link_status_i) begin
			irq_event[IRQ_LINK_BIT] = 1'b1;
		end

		// core reset pulse; the request bit is visible for one cycle only
		state_next.core_req = 1'b0;
		state_next.full_req = 1'b0;
		if (state_reg.core_req | state_reg.full_req) begin
			state_next.core_cnt = CORE_RESET_CYCLES;
		end else if (state_reg.core_cnt != '0) begin
			state_next.core_cnt = state_reg.core_cnt - 1'b1;
		end

		// cable test sequencer
		state_next.tdr_pulse = 1'b0;
		if (state_reg.core_rst) begin
			// core reset aborts a running test, flags are register file
			state_next.tdr = TDR_IDLE;
			state_next.ct_start = 1'b0;
		end else if (launch) begin
			state_next.tdr = TDR_RUN;
			state_next.tdr_pulse = 1'b1;
			state_next.ct_start = 1'b0;
			state_next.ct_done = 1'b0;
			state_next.ct_fail = 1'b0;
		end else begin
			unique case (state_reg.tdr)
				TDR_IDLE: begin
					state_next.tdr = TDR_IDLE;
				end
				TDR_RUN: begin
					if (tdr_done_i) begin
						state_next.tdr = TDR_IDLE;
						state_next.ct_done = 1'b1;
						state_next.ct_fail = tdr_fail_i;
						irq_event[IRQ_DONE_BIT] = 1'b1;
						irq_event[IRQ_FAIL_BIT] = tdr_fail_i;
					end
				end
			endcase
		end

		// power mode requests apply one cycle after the write, then clear
		state_next.stby_req = 1'b0;
		state_next.norm_req = 1'b0;
		if (state_reg.stby_req) begin
			state_next.pwr_normal = 1'b0;
		end else if (state_reg.norm_req) begin
			state_next.pwr_normal = 1'b1;
		end
		if (state_next.pwr_normal != state_reg.pwr_normal) begin
			irq_event[IRQ_PWR_BIT] = 1'b1;
		end
		// sleep is never entered while permission is withheld
		state_next.sleep_enter = sleep_request_i & state_reg.sleep_en
			& state_reg.pwr_normal;

		// register writes; writing zero to a one-shot bit does nothing
		unique case (idx)
			IDX_CABLE_TEST: begin
				if (wr_hi) begin
					state_next.ct_auto = wdata[CT_AUTO_BIT];
					if (wdata[CT_START_BIT]) begin
						state_next.ct_start = 1'b1;
					end
				end
			end
			IDX_SOFT_RESET: begin
				if (wr_lo) begin
					state_next.sr_spare[REG_W/2-1:0] = wdata[REG_W/2-1:0]
						& SR_SPARE_MASK[REG_W/2-1:0];
				end
				if (wr_hi) begin
					state_next.sr_spare[REG_W-1:REG_W/2] = wdata[REG_W-1:REG_W/2]
						& SR_SPARE_MASK[REG_W-1:REG_W/2];
					state_next.full_req = wdata[SR_FULL_BIT];
					state_next.core_req = wdata[SR_CORE_BIT];
				end
			end
			IDX_LOW_POWER: begin
				if (wr_lo) begin
					state_next.sleep_en = wdata[LP_SLEEP_BIT];
					state_next.auto_mode = wdata[LP_AUTO_BIT];
					state_next.lp_spare = wdata[LP_SPARE_W-1:0];
				end
				if (wr_hi) begin
					state_next.line_energy_detect_enable = wdata[LP_ED_BIT];
				end
			end
			IDX_PWR_REQUEST: begin
				if (wr_lo) begin
					state_next.stby_req = wdata[PM_STANDBY_BIT];
					state_next.norm_req = wdata[PM_NORMAL_BIT];
				end
			end
			IDX_IRQ_STATUS: begin
				if (wr_lo) begin
					irq_clear = wdata[IRQ_W-1:0];
				end
			end
			IDX_IRQ_MASK: begin
				if (wr_lo) begin
					state_next.irq_mask = wdata[IRQ_W-1:0];
				end
			end
			default: begin
				state_next.irq_mask = state_next.irq_mask;
			end
		endcase

		// sticky status: a new event beats a simultaneous clear
		state_next.irq_stat = (state_reg.irq_stat & ~irq_clear) | irq_event;

		// full soft reset: register file back to defaults, straps re-read
		if (state_reg.full_req) begin
			state_next.phy_addr = strap_phy_address_i;
			state_next.ct_start = 1'b0;
			state_next.ct_auto = 1'b0;
			state_next.ct_done = 1'b0;
			state_next.ct_fail = 1'b0;
			state_next.tdr = TDR_IDLE;
			state_next.sr_spare = REG_RESET;
			state_next.line_energy_detect_enable = 1'b0;
			state_next.sleep_en = 1'b0;
			state_next.auto_mode = strap_auto_mode_i;
			state_next.lp_spare = LP_SPARE_RESET;
			state_next.stby_req = 1'b0;
			state_next.norm_req = 1'b0;
			state_next.pwr_normal = strap_auto_mode_i;
			state_next.irq_stat = IRQ_RESET;
			state_next.irq_mask = IRQ_RESET;
		end

		state_next.core_rst = (state_next.core_cnt != '0);
		state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

		// power-on reset; straps are caught by this clocked path
		if (rst_i) begin
			state_next.waitreq = 1'b1;
			state_next.rdata = '0;
			state_next.phy_addr = strap_phy_address_i;
			state_next.ct_start = 1'b0;
			state_next.ct_auto = 1'b0;
			state_next.ct_done = 1'b0;
			state_next.ct_fail = 1'b0;
			state_next.tdr = TDR_IDLE;
			state_next.tdr_pulse = 1'b0;
			state_next.sr_spare = REG_RESET;
			state_next.full_req = 1'b0;
			state_next.core_req = 1'b0;
			state_next.core_cnt = '0;
			state_next.core_rst = 1'b0;
			state_next.link_prev = 1'b0;
			state_next.link_flags = REG_RESET;
			state_next.line_energy_detect_enable = 1'b0;
			state_next.sleep_en = 1'b0;
			state_next.auto_mode = strap_auto_mode_i;
			state_next.lp_spare = LP_SPARE_RESET;
			state_next.stby_req = 1'b0;
			state_next.norm_req = 1'b0;
			state_next.pwr_normal = strap_auto_mode_i;
			state_next.sleep_enter = 1'b0;
			state_next.irq_stat = IRQ_RESET;
			state_next.irq_mask = IRQ_RESET;
			state_next.irq = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	assign avs_readdata_o = state_reg.rdata;
	assign avs_waitrequest_o = state_reg.waitreq;
	assign tdr_start_o = state_reg.tdr_pulse;
	assign core_reset_o = state_reg.core_rst;
	assign line_energy_detect_enable_o = state_reg.line_energy_detect_enable;
	assign sleep_allow_o = state_reg.sleep_en;
	assign sleep_enter_o = state_reg.sleep_enter;
	assign power_normal_o = state_reg.pwr_normal;
	assign irq_o = state_reg.irq;
endmodule

// *** hdl/phy_mgmt_pkg.sv ***
// constants, types and register map for the phy management register slice
// How it works
// - strap PHY address captured at reset, read-only
// - start bit launches cable test, self-clears
// - auto-run starts cable test on link loss
// - full soft reset restores core and registers
// - core-only reset keeps register contents, self-clears
// - link-up and link-down flags in bits 15,14
// - send-data state bit 13, link status 12
// - energy detect enable gates line energy monitor
// - sleep entry only while sleep permitted
// - strap-loaded auto mode picks power-up state
// - bit 4 request moves to standby, self-clears
// - bit 0 request moves to normal, self-clears
package phy_mgmt_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 10;
	localparam int ADDR_LSB = 2;
	localparam int PHY_ADDR_W = 5;

	// register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_STRAP_ADDR = 10'h019;
	localparam logic [IDX_W-1:0] IDX_CABLE_TEST = 10'h01e;
	localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 10'h01f;
	localparam logic [IDX_W-1:0] IDX_LINK_FLAGS = 10'h180;
	localparam logic [IDX_W-1:0] IDX_LOW_POWER = 10'h18b;
	localparam logic [IDX_W-1:0] IDX_PWR_REQUEST = 10'h18c;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h190;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h191;

	localparam int CT_START_BIT = 15;
	localparam int CT_AUTO_BIT = 14;
	localparam int CT_DONE_BIT = 1;
	localparam int CT_FAIL_BIT = 0;
	localparam int SR_FULL_BIT = 15;
	localparam int SR_CORE_BIT = 14;
	localparam logic [REG_W-1:0] SR_SPARE_MASK = 16'h3fdf;
	localparam int LS_UP_BIT = 15;
	localparam int LS_DOWN_BIT = 14;
	localparam int LS_SEND_BIT = 13;
	localparam int LS_STATUS_BIT = 12;
	localparam int LS_DESCR_BIT = 2;
	localparam int LS_LOC_BIT = 1;
	localparam int LS_REM_BIT = 0;
	localparam int LP_ED_BIT = 8;
	localparam int LP_SLEEP_BIT = 7;
	localparam int LP_AUTO_BIT = 6;
	localparam int LP_SPARE_W = 6;
	localparam int PM_STANDBY_BIT = 4;
	localparam int PM_NORMAL_BIT = 0;

	localparam int IRQ_W = 4;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;
	localparam int IRQ_LINK_BIT = 2;
	localparam int IRQ_PWR_BIT = 3;

	localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	localparam logic [LP_SPARE_W-1:0] LP_SPARE_RESET = 6'h00;

	localparam int CLK_PERIOD_NS = 10;
	localparam int CORE_RESET_NS = 40;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CORE_RESET_CYCLES =
		CNT_W'((CORE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [0:0] {
		TDR_IDLE = 1'b0,
		TDR_RUN = 1'b1
	} tdr_state_t;
endpackage

// *** tb/phy_mgmt_chk.sv ***
// port-level assertions for the management register slice
`timescale 1ns/1ps
module phy_mgmt_chk
	import phy_mgmt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [DATA_W-1:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic sleep_request_i,
	input wire logic tdr_start_o,
	input wire logic core_reset_o,
	input wire logic sleep_allow_o,
	input wire logic sleep_enter_o,
	input wire logic power_normal_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic req = avs_read_i | avs_write_i;
	property p_wait_ans;
		req && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
	property p_wait_idle;
		!req |=> avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
	property p_wait_pulse;
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
	property p_rd_hi;
		avs_readdata_o[31:16] == 16'h0000;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read data set");
	property p_start_pulse;
		tdr_start_o |=> !tdr_start_o;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_core_len;
		$rose(core_reset_o) |-> core_reset_o[*4] ##1 !core_reset_o;
	endproperty
	a_core_len: assert property (p_core_len) else $error("core reset width");
	property p_core_cause;
		$rose(core_reset_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) ||
			$past(avs_write_i, 3) || $past(avs_write_i, 4);
	endproperty
	a_core_cause: assert property (p_core_cause) else $error("core reset uncaused");
	property p_sleep;
		sleep_enter_o == $past(sleep_request_i && sleep_allow_o && power_normal_o);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
	// full soft reset may move the mode together with the core reset
	property p_pwr_cause;
		$changed(power_normal_o) |-> $past(avs_write_i, 2) || $past(avs_write_i, 3) ||
			core_reset_o || $past(core_reset_o);
	endproperty
	a_pwr_cause: assert property (p_pwr_cause) else $error("mode change uncaused");
	c_start: cover property (tdr_start_o);
	c_core: cover property ($rose(core_reset_o));
	c_sleep: cover property (sleep_enter_o);
	c_irq: cover property (irq_o);
endmodule

// *** tb/phy_mgmt_control_status_regs_tb.sv ***
// self-checking bench for the management register slice
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module phy_mgmt_control_status_regs_tb import phy_mgmt_pkg::*;;
	logic clk_i, rst_i, avs_read_i, avs_write_i, strap_auto_mode_i, sleep_request_i;
	logic link_up_i, link_down_i, send_data_i, link_status_i, descr_lock_i;
	logic loc_rcvr_i, rem_rcvr_i, tdr_done_i, tdr_fail_i;
	logic [ADDR_W-1:0] avs_address_i;
	logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
	logic [DATA_W/8-1:0] avs_byteenable_i;
	logic [PHY_ADDR_W-1:0] strap_phy_address_i;
	logic avs_waitrequest_o, tdr_start_o, core_reset_o, line_energy_detect_enable_o;
	logic sleep_allow_o, sleep_enter_o, power_normal_o, irq_o;
	int error_cnt, n_checks, cyc;
	logic [15:0] q, d;
	logic [6:0] lv;
	localparam logic [11:0] A_ST = {IDX_STRAP_ADDR, 2'b00};
	localparam logic [11:0] A_CT = {IDX_CABLE_TEST, 2'b00};
	localparam logic [11:0] A_SR = {IDX_SOFT_RESET, 2'b00};
	localparam logic [11:0] A_LS = {IDX_LINK_FLAGS, 2'b00};
	localparam logic [11:0] A_LP = {IDX_LOW_POWER, 2'b00};
	localparam logic [11:0] A_PM = {IDX_PWR_REQUEST, 2'b00};
	localparam logic [11:0] A_IS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] A_MK = {IDX_IRQ_MASK, 2'b00};
	phy_mgmt_control_status_regs phy_mgmt_control_status_regs_i (.*);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task end_of_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hung handshakes end here rather than spinning forever
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	function automatic logic [15:0] flags(input logic [6:0] v);
		return {v[6:3], 9'h000, v[2:0]};
	endfunction
	task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] v);
		@(posedge clk_i);
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= {16'h0000, v};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o[15:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		`CHK(q, e)
	endtask
	task automatic see_start;
		for (int i = 0; i < 8 && tdr_start_o !== 1'b1; i++) @(posedge clk_i);
		`CHK(tdr_start_o, 1'b1)
	endtask
	task automatic core_len;
		int n;
		n = 0;
		for (int i = 0; i < 10 && core_reset_o !== 1'b1; i++) @(posedge clk_i);
		while (core_reset_o === 1'b1 && n < 10) begin
			n++;
			@(posedge clk_i);
		end
		`CHK(CNT_W'(n), CORE_RESET_CYCLES)
	endtask
	task automatic link_drop;
		link_status_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		link_status_i <= 1'b0;
	endtask
	initial begin
		void'($urandom(32'h7f98a1e9));
		{rst_i, avs_read_i, avs_write_i, sleep_request_i, tdr_done_i, tdr_fail_i} = 6'h20;
		{link_up_i, link_down_i, send_data_i, link_status_i} = 4'h0;
		{descr_lock_i, loc_rcvr_i, rem_rcvr_i} = 3'h0;
		avs_address_i = '0;
		avs_writedata_i = '0;
		avs_byteenable_i = 4'hf;
		strap_phy_address_i = PHY_ADDR_W'($urandom);
		strap_auto_mode_i = 1'($urandom);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK(power_normal_o, strap_auto_mode_i)
		rd(A_ST, {11'h000, strap_phy_address_i});
		rd(A_CT, 16'h0000);
		rd(A_SR, 16'h0000);
		rd(A_LS, 16'h0000);
		rd(A_LP, {9'h000, strap_auto_mode_i, 6'h00});
		rd(A_PM, 16'h0000);
		acc(1'b1, 12'h100, 16'hffff);
		rd(12'h100, 16'h0000);
		acc(1'b1, A_ST, 16'hffff);
		rd(A_ST, {11'h000, strap_phy_address_i});
		for (int k = 0; k < 10; k++) begin
			lv = (k == 0) ? 7'h7f : 7'($urandom);
			{link_up_i, link_down_i, send_data_i, link_status_i} <= lv[6:3];
			{descr_lock_i, loc_rcvr_i, rem_rcvr_i} <= lv[2:0];
			rd(A_LS, flags(lv));
		end
		for (int k = 0; k < 6; k++) begin
			d = 16'($urandom);
			acc(1'b1, A_LP, d);
			rd(A_LP, d & 16'h01ff);
			`CHK(line_energy_detect_enable_o, d[8])
			`CHK(sleep_allow_o, d[7])
		end
		acc(1'b1, A_PM, 16'h0001);
		repeat (3) @(posedge clk_i);
		`CHK(power_normal_o, 1'b1)
		sleep_request_i <= 1'b1;
		acc(1'b1, A_LP, 16'h0080);
		repeat (3) @(posedge clk_i);
		`CHK(sleep_enter_o, 1'b1)
		acc(1'b1, A_LP, 16'h0100);
		repeat (3) @(posedge clk_i);
		`CHK(sleep_enter_o, 1'b0)
		acc(1'b1, A_PM, 16'h0011);
		repeat (3) @(posedge clk_i);
		`CHK(power_normal_o, 1'b0)
		rd(A_PM, 16'h0000);
		acc(1'b0, A_IS, 16'h0000);
		`CHK(q[IRQ_PWR_BIT], 1'b1)
		sleep_request_i <= 1'b0;
		`CHK(irq_o, 1'b0)
		acc(1'b1, A_MK, 16'h0001);
		rd(A_MK, 16'h0001);
		acc(1'b1, A_CT, 16'h8000);
		see_start;
		rd(A_CT, 16'h0000);
		{tdr_done_i, tdr_fail_i} <= 2'b11;
		@(posedge clk_i);
		tdr_done_i <= 1'b0;
		rd(A_CT, 16'h0003);
		`CHK(irq_o, 1'b1)
		acc(1'b1, A_IS, 16'h000f);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		rd(A_IS, 16'h0000);
		acc(1'b1, A_CT, 16'h8000);
		see_start;
		rd(A_CT, 16'h0000);
		acc(1'b1, A_CT, 16'h4000);
		link_drop();
		see_start;
		rd(A_CT, 16'h4000);
		rd(A_IS, 16'h0004);
		acc(1'b1, A_CT, 16'h0000);
		link_drop();
		repeat (6) begin
			@(posedge clk_i);
			`CHK(tdr_start_o, 1'b0)
		end
		acc(1'b1, A_LP, 16'h0185);
		acc(1'b1, A_SR, 16'h4000);
		core_len;
		rd(A_LP, 16'h0185);
		strap_phy_address_i <= ~strap_phy_address_i;
		acc(1'b1, A_SR, 16'h8000);
		core_len;
		rd(A_SR, 16'h0000);
		rd(A_LP, {9'h000, strap_auto_mode_i, 6'h00});
		rd(A_ST, {11'h000, strap_phy_address_i});
		`CHK(power_normal_o, strap_auto_mode_i)
		`CHK(line_energy_detect_enable_o, 1'b0)
		`CHK(sleep_allow_o, 1'b0)
		rd(A_MK, 16'h0000);
		rd(A_IS, 16'h0000);
		end_of_test;
	end
endmodule
bind phy_mgmt_control_status_regs phy_mgmt_chk phy_mgmt_chk_i (.*);
